/* File: logic/uif_usb_irq_flags.sv */
// Operation
// [R1] Index 0x0C reads low eight bits of last frame number, read-only.
// [R2] Index 0x0D bits 2..0 give frame bits 10..8; upper bits zero.
// [R3] USB flags cannot be set or cleared by software writes.
// [R4] USB interrupt request is high while any flag is one.
// [R5] Request reaches processor only when the extended enable bit is set.
// [R6] Reading a flag register returns flags, then clears them all.
// [R7] Index 0x02 holds IN endpoint 3..0 pending flags, resets zero.
// [R8] Pending flag reads one while active, cleared by register read.
// [R9] Bits 7..4 of IN endpoint flags read zero, writes ignored.
// [R10] Each valid start-of-frame token loads the eleven-bit frame number.
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module uif_usb_irq_flags (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Protocol engine events
  input wire logic [3:0] in_ep_event,
  input wire logic sof_valid,
  input wire logic sof_crc_ok,
  input wire logic [10:0] sof_frame,
  // Interrupt to processor
  output logic usb_irq
);

  typedef struct packed {
    logic [3:0] in_flags;
    logic [1:0] evt_sts;
    logic [1:0] evt_mask;
    logic irq_en;
    logic [31:0] rdata;
    logic wait_n;
    logic irq;
  } uif_state_t;

  uif_state_t s_q;
  uif_state_t s_d;
  uif_frame_if fr ();

  // ----------------------------------------------------------------
  // Frame capture
  // ----------------------------------------------------------------
  uif_sof_capture u_cap (
    .clk(clk),
    .reset_n(reset_n),
    .sof_valid(sof_valid),
    .sof_crc_ok(sof_crc_ok),
    .sof_frame(sof_frame),
    .fr(fr)
  );

  logic [3:0] idx;
  logic req;
  logic wr_lo;
  assign idx = avs_address[5:2];
  // One wait state: answer in the cycle after the request is seen
  assign req = (avs_read || avs_write) && !s_q.wait_n;
  assign wr_lo = req && avs_write && avs_byteenable[0];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.wait_n = req;
    s_d.in_flags = s_q.in_flags;
    // Read of flag register clears it; [R6]
    if (req && avs_read && idx == uif_pkg::IDX_IN_EP_IRQ) begin
      s_d.in_flags = uif_pkg::RST_IN_EP; // [R8]
    end
    // A new event in the clearing cycle is kept, set beats clear
    s_d.in_flags = s_d.in_flags | in_ep_event; // [R8]
    // Sticky events, write one to clear
    if (wr_lo && idx == uif_pkg::IDX_EVT_STATUS) begin
      s_d.evt_sts = s_q.evt_sts & ~avs_writedata[1:0];
    end
    if (fr.sof_seen) begin
      s_d.evt_sts[uif_pkg::EVT_SOF] = 1'b1;
    end
    if (|in_ep_event) begin
      s_d.evt_sts[uif_pkg::EVT_IN_EP] = 1'b1;
    end
    if (wr_lo && idx == uif_pkg::IDX_EVT_MASK) begin
      s_d.evt_mask = avs_writedata[1:0];
    end
    if (wr_lo && idx == uif_pkg::IDX_CTRL) begin
      s_d.irq_en = avs_writedata[uif_pkg::CTRL_IRQ_EN];
    end
    // Writes to flag and frame registers fall through: [R3] [R9]
    s_d.rdata = 32'h0000_0000;
    if (req && avs_read) begin
      unique case (idx)
        uif_pkg::IDX_IN_EP_IRQ:
          s_d.rdata[7:0] = {4'h0, s_q.in_flags}; // [R7] [R9] [R6]
        uif_pkg::IDX_FRAME_LO:
          s_d.rdata[7:0] = fr.frame[7:0]; // [R1]
        uif_pkg::IDX_FRAME_HI:
          s_d.rdata[7:0] = {5'h00, fr.frame[10:8]}; // [R2]
        uif_pkg::IDX_EVT_STATUS:
          s_d.rdata[1:0] = s_q.evt_sts;
        uif_pkg::IDX_EVT_MASK:
          s_d.rdata[1:0] = s_q.evt_mask;
        uif_pkg::IDX_CTRL:
          s_d.rdata[0] = s_q.irq_en;
        default:
          s_d.rdata = 32'h0000_0000;
      endcase
    end
    // Flags plus unmasked events, gated by the enable
    s_d.irq = s_d.irq_en && ((|s_d.in_flags) // [R4] [R5]
              || (|(s_d.evt_sts & s_d.evt_mask)));
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '{in_flags: uif_pkg::RST_IN_EP, evt_sts: uif_pkg::RST_EVT,
               evt_mask: uif_pkg::RST_EVT, irq_en: 1'b0,
               rdata: 32'h0000_0000, wait_n: 1'b0, irq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = !s_q.wait_n;
  assign usb_irq = s_q.irq;

endmodule
`default_nettype wire

/* File: logic/uif_pkg.sv */
package uif_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_IN_EP_IRQ = 4'h2;
  localparam logic [3:0] IDX_FRAME_LO = 4'hc;
  localparam logic [3:0] IDX_FRAME_HI = 4'hd;
  localparam logic [3:0] IDX_EVT_STATUS = 4'h8;
  localparam logic [3:0] IDX_EVT_MASK = 4'h9;
  localparam logic [3:0] IDX_CTRL = 4'ha;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int N_IN_EP = 4;
  localparam int FRAME_W = 11;
  localparam int FRAME_HI_W = 3;
  localparam int N_EVT = 2;
  localparam int EVT_SOF = 0;
  localparam int EVT_IN_EP = 1;
  localparam int CTRL_IRQ_EN = 0;
  localparam logic [3:0] RST_IN_EP = 4'h0;
  localparam logic [10:0] RST_FRAME = 11'h000;
  localparam logic [1:0] RST_EVT = 2'h0;
  localparam logic [7:0] RST_READ = 8'h00;

endpackage

/* File: logic/uif_frame_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Captured frame number and a pulse for each accepted frame start
interface uif_frame_if;
  logic [10:0] frame;
  logic sof_seen;
  modport cap (output frame, output sof_seen);
  modport use_side (input frame, input sof_seen);
endinterface
`default_nettype wire

/* File: logic/uif_sof_capture.sv */
`timescale 1ns/1ps
`default_nettype none
module uif_sof_capture (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Start-of-frame token from the protocol engine
  input wire logic sof_valid,
  input wire logic sof_crc_ok,
  input wire logic [10:0] sof_frame,
  // Captured frame towards the register file
  uif_frame_if.cap fr
);

  typedef struct packed {
    logic [10:0] frame;
    logic sof_seen;
  } uif_cap_t;

  uif_cap_t s_q;
  uif_cap_t s_d;

  // ----------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------
  // Corrupted tokens must not disturb the stored number
  always_comb begin
    s_d = s_q;
    s_d.sof_seen = 1'b0;
    if (sof_valid && sof_crc_ok) begin
      s_d.frame = sof_frame; // [R10]
      s_d.sof_seen = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '{frame: uif_pkg::RST_FRAME, sof_seen: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign fr.frame = s_q.frame;
  assign fr.sof_seen = s_q.sof_seen;

endmodule
`default_nettype wire

/* File: dv/uif_props.sv */
`timescale 1ns/1ps
`default_nettype none
module uif_props (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bus
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Events
  input wire logic [3:0] in_ep_event,
  input wire logic sof_valid,
  input wire logic sof_crc_ok,
  input wire logic [10:0] sof_frame
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Reads taken this edge, per register
  wire logic rd_in = avs_read && avs_waitrequest && avs_address == 6'h08;
  wire logic rd_lo = avs_read && avs_waitrequest && avs_address == 6'h30;
  wire logic rd_hi = avs_read && avs_waitrequest && avs_address == 6'h34;
  bus_answer_a:
    assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("no answer");
  bus_one_a:
    assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer too long");
  data_idle_a:
    assert property (avs_waitrequest |-> avs_readdata == 32'h0)
    else $error("data while idle");
  in_upper_a:
    assert property (rd_in |=> avs_readdata[31:4] == 28'h0)
    else $error("flag upper bits");
  frame_upper_a:
    assert property (rd_hi |=> avs_readdata[31:3] == 29'h0)
    else $error("frame upper bits");
  flag_clear_a:
    assert property (rd_in && in_ep_event == 4'h0 ##1 in_ep_event == 4'h0
      ##1 in_ep_event == 4'h0 ##1 rd_in |=> avs_readdata == 32'h0)
    else $error("flags not cleared");
  flag_set_a:
    assert property (in_ep_event != 4'h0 ##5 rd_in |=> (avs_readdata[3:0]
      & $past(in_ep_event, 6)) == $past(in_ep_event, 6))
    else $error("flag lost");
  frame_load_a:
    assert property (sof_valid && sof_crc_ok ##1 !sof_valid ##1 !sof_valid
      && rd_lo |=> avs_readdata[7:0] == $past(sof_frame[7:0], 3))
    else $error("frame not loaded");
endmodule
bind uif_usb_irq_flags uif_props u_props (.clk(clk), .reset_n(reset_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .in_ep_event(in_ep_event), .sof_valid(sof_valid),
  .sof_crc_ok(sof_crc_ok), .sof_frame(sof_frame));
`default_nettype wire

/* File: dv/test_uif_usb_irq_flags.sv */
`timescale 1ns/1ps
`default_nettype none
module test_uif_usb_irq_flags;
  logic clk, reset_n, avs_read, avs_write, sof_valid, sof_crc_ok;
  logic avs_waitrequest, usb_irq;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable, in_ep_event, fl, e;
  logic [10:0] sof_frame, fr;
  logic [7:0] q[$];
  int num_errors, compares;
  uif_usb_irq_flags uut (.clk(clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .in_ep_event(in_ep_event), .sof_valid(sof_valid),
    .sof_crc_ok(sof_crc_ok), .sof_frame(sof_frame), .usb_irq(usb_irq));
  // Clock at 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task final_report;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Bus cycle; held until waitrequest is seen low, bounded wait
  task acc(input logic w, input logic [5:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    n = 0;
    // Waitrequest is sampled at the rising edge, as the slave sees it
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      num_errors++;
      final_report;
    end
    // Released at the answering edge, not before
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task rd(input logic [5:0] a, input logic [7:0] x);
    q.push_back(x);
    acc(1'b0, a, 8'h00);
  endtask
  // One-cycle pulses of endpoint events and frame starts
  task ev(input logic [3:0] v);
    @(posedge clk);
    in_ep_event <= v;
    fl = fl | v;
    @(posedge clk);
    in_ep_event <= 4'h0;
  endtask
  task sof(input logic [10:0] f, input logic ok);
    @(posedge clk);
    sof_valid <= 1'b1;
    sof_crc_ok <= ok;
    sof_frame <= f;
    @(posedge clk);
    sof_valid <= 1'b0;
  endtask
  // Answered reads are compared with the oldest note
  always @(posedge clk) begin
    if (avs_read && !avs_waitrequest) chk(avs_readdata, {24'h0, q.pop_front()});
  end
  // Main sequence
  initial begin
    {reset_n, avs_read, avs_write, sof_valid, sof_crc_ok} = 5'h0;
    {avs_address, avs_writedata, in_ep_event, sof_frame, fl} = '0;
    avs_byteenable = 4'hf;
    num_errors = 0;
    compares = 0;
    void'($urandom(32'h982a));
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    rd(6'h08, 8'h00);
    rd(6'h30, 8'h00);
    rd(6'h34, 8'h00);
    rd(6'h3c, 8'h00);
    for (int i = 0; i < 8; i++) begin
      e = 4'($urandom);
      ev(e);
      acc(1'b1, 6'h08, 8'hff);
      rd(6'h08, {4'h0, fl});
      fl = 4'h0;
      rd(6'h08, 8'h00);
      fr = 11'($urandom);
      sof(fr, 1'b1);
      rd(6'h30, fr[7:0]);
      rd(6'h34, {5'h0, fr[10:8]});
      sof(~fr, 1'b0);
      rd(6'h30, fr[7:0]);
    end
    acc(1'b1, 6'h28, 8'h01);
    acc(1'b1, 6'h20, 8'h03);
    ev(4'h4);
    @(negedge clk);
    chk({31'h0, usb_irq}, 32'h1);
    rd(6'h08, 8'h04);
    acc(1'b1, 6'h20, 8'h03);
    @(negedge clk);
    chk({31'h0, usb_irq}, 32'h0);
    acc(1'b1, 6'h28, 8'h00);
    ev(4'h1);
    @(negedge clk);
    chk({31'h0, usb_irq}, 32'h0);
    repeat (4) @(posedge clk);
    final_report;
  end
endmodule
`default_nettype wire
